// ==== cagu_top.sv ====
// Purpose: address generation unit: branch targets, operand addresses, stack frames
// Assumes: memory answers a read in the cycle after the request
// Notes: one stack byte moves per cycle
// Behaviour
// - relative branch adds signed 8 or 16 bit displacement to next address
// - immediate target loads 20 bits; 16-bit form zeroes top four bits
// - table call picks entry in 0080H..00BFH, loads two bytes as pc
// - table call targets stay below 10000H, upper pc bits zero
// - register direct target is code bank over selected pair
// - 3-bit field picks byte register, 2-bit field picks pair
// - direct operand maps into F0000H..FFFFFH, or data bank when prefixed
// - short direct reaches FFE20H..FFF1FH only, word form even
// - special register operand reaches FFF00H..FFFFFH, word form even
// - register indirect uses pair, top bits F or data bank
// - based operand adds byte or word offset to pair, stack or immediate
// - based indexed adds selected byte register to third pair
// - stack lives only in internal RAM, stack pointer addresses it
// - push writes high at sp-1, low at sp-2, sp minus two
// - pop reads low at sp, high at sp+1, sp plus two
// - call writes 00H, pc high, mid, low downward, sp minus four
// - return reads pc low, mid, high upward, sp plus four
// - interrupt or break writes status, pc high, mid, low, sp minus four
// - interrupt or break return restores frame, sp plus four
`timescale 1ns/1ps
module cagu_top (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// branch request
	input wire logic branch_in,
	input wire cagu_pkg::cagu_br_t branch_form_in,
	input wire logic imm_wide_in,
	input wire logic disp_wide_in,
	input wire logic [19:0] imm20_in,
	input wire logic [15:0] disp_in,
	input wire logic [4:0] table_index_in,
	input wire logic [19:0] next_pc_in,
	input wire logic [3:0] code_bank_in,
	// register file view
	input wire logic [2:0] byte_sel_in,
	input wire logic [1:0] pair_sel_in,
	input wire logic [63:0] bank_regs_in,
	input wire logic [3:0] data_bank_register_in,
	input wire logic [7:0] status_word_in,
	// operand request
	input wire cagu_pkg::cagu_op_t op_form_in,
	input wire cagu_pkg::cagu_base_t base_sel_in,
	input wire logic seg_in,
	input wire logic word_in,
	input wire logic wide_offset_in,
	input wire logic [15:0] imm16_in,
	input wire logic [15:0] offset_in,
	input wire logic [7:0] field_in,
	// stack request
	input wire logic stack_req_in,
	input wire cagu_pkg::cagu_stk_t stack_op_in,
	// memory
	input wire logic [7:0] mem_rdata_in,
	output logic mem_req_out,
	output logic mem_we_out,
	output logic [19:0] mem_addr_out,
	output logic [7:0] mem_wdata_out,
	// results
	output logic [19:0] operand_addr_out,
	output logic [7:0] byte_reg_out,
	output logic [15:0] pair_out,
	output logic [19:0] program_counter_out,
	output logic [15:0] stack_pointer_out,
	output logic [7:0] status_word_out,
	output logic [15:0] pop_data_out,
	output logic status_load_out,
	output logic pair_load_out,
	output logic busy_out,
	output logic done_out
);
	typedef enum logic [1:0] {CAGU_IDLE, CAGU_MOVE, CAGU_WAIT, CAGU_END} cagu_state_t;
	typedef struct packed {
		cagu_state_t state;
		cagu_pkg::cagu_stk_t op;
		logic [2:0] step;
		logic [2:0] last;
		logic [19:0] pc;
		logic [15:0] sp;
		logic [15:0] base_sp;
		logic [7:0] status;
		logic [23:0] frame;
		logic req;
		logic we;
		logic [19:0] addr;
		logic [7:0] wdata;
		logic rd_pending;
		logic [2:0] rd_step;
		logic done;
		logic status_load;
		logic pair_load;
		logic [15:0] pop_data;
		logic table_fetch;
	} cagu_state_s_t;
	cagu_state_s_t r;
	cagu_state_s_t next_r;

	logic [15:0] pair_val;
	logic [7:0] byte_val;
	logic [15:0] third_val;
	logic [7:0] index_byte;
	logic [15:0] disp_ext;
	logic [15:0] push_pair;

	// byte registers X A C B E D L H sit at bank_regs_in[8*i +: 8]
	always_comb begin
		byte_val = bank_regs_in[{byte_sel_in, 3'h0} +: 8];
		pair_val = bank_regs_in[{pair_sel_in, 4'h0} +: 16];
		third_val = bank_regs_in[{cagu_pkg::THIRD_PAIR_SEL, 4'h0} +: 16];
		index_byte = byte_val;
		disp_ext = disp_wide_in ? disp_in : {{8{disp_in[7]}}, disp_in[7:0]};
		push_pair = pair_val;
	end

	cagu_operand u_operand (
		.form_in(op_form_in),
		.base_sel_in(base_sel_in),
		.seg_in(seg_in),
		.word_in(word_in),
		.wide_offset_in(wide_offset_in),
		.imm16_in(imm16_in),
		.offset_in(offset_in),
		.field_in(field_in),
		.pair_in(pair_val),
		.third_pair_in(third_val),
		.index_byte_in(index_byte),
		.stack_pointer_in(r.sp),
		.data_bank_register_in(data_bank_register_in),
		.addr_out(operand_addr_out)
	);

	// status push is requested with the accumulator slot and seg_in high
	logic status_push;
	assign status_push = seg_in && (pair_sel_in == 2'h0);

	// byte to write at a given step of a descending frame
	function automatic logic [7:0] frame_byte(input cagu_pkg::cagu_stk_t op, input logic [2:0] step,
		input logic [19:0] pc, input logic [7:0] st, input logic [15:0] pr);
		logic [7:0] b;
		b = 8'h00;
		if (op == cagu_pkg::CAGU_STK_PUSH) begin
			if (step == 3'd0)
				b = (pair_sel_in == 2'h0 && status_push) ? st : pr[15:8];
			else
				b = status_push ? cagu_pkg::STATUS_PAD : pr[7:0];
		end else begin
			unique case (step)
				3'd0: b = (op == cagu_pkg::CAGU_STK_CALL) ? cagu_pkg::CALL_PAD : st;
				3'd1: b = {4'h0, pc[19:16]};
				3'd2: b = pc[15:8];
				default: b = pc[7:0];
			endcase
		end
		return b;
	endfunction

	always_comb begin
		next_r = r;
		next_r.req = 1'b0;
		next_r.we = 1'b0;
		next_r.done = 1'b0;
		next_r.status_load = 1'b0;
		next_r.pair_load = 1'b0;
		next_r.rd_pending = r.req && !r.we;
		next_r.rd_step = r.step;
		// capture read data one cycle after its request
		if (r.rd_pending) begin
			unique case (r.op)
				cagu_pkg::CAGU_STK_POP: begin
					if (r.rd_step == 3'd1)
						next_r.pop_data[7:0] = mem_rdata_in;
					else if (r.status_load)
						next_r.status = mem_rdata_in;
					else
						next_r.pop_data[15:8] = mem_rdata_in;
				end
				default: begin
					unique case (r.rd_step)
						3'd1: next_r.frame[7:0] = mem_rdata_in;
						3'd2: next_r.frame[15:8] = mem_rdata_in;
						3'd3: next_r.frame[23:16] = mem_rdata_in;
						default: next_r.status = mem_rdata_in;
					endcase
				end
			endcase
		end
		unique case (r.state)
			CAGU_IDLE: begin
				if (branch_in) begin
					unique case (branch_form_in)
						cagu_pkg::CAGU_BR_REL: next_r.pc = next_pc_in + {{4{disp_ext[15]}}, disp_ext};
						cagu_pkg::CAGU_BR_IMM: next_r.pc = imm_wide_in ? imm20_in : {4'h0, imm20_in[15:0]};
						cagu_pkg::CAGU_BR_REG: next_r.pc = {code_bank_in, pair_val};
						cagu_pkg::CAGU_BR_TABLE: begin
							// fetch target from table, then push the return frame
							next_r.table_fetch = 1'b1;
							next_r.frame = {4'h0, next_pc_in};
							next_r.state = CAGU_MOVE;
							next_r.op = cagu_pkg::CAGU_STK_POP;
							next_r.step = 3'd0;
							next_r.last = 3'd2;
						end
						default: next_r.pc = r.pc;
					endcase
				end else if (stack_req_in) begin
					next_r.op = stack_op_in;
					next_r.step = 3'd0;
					next_r.base_sp = r.sp;
					next_r.frame = {4'h0, next_pc_in};
					next_r.state = CAGU_MOVE;
					unique case (stack_op_in)
						cagu_pkg::CAGU_STK_PUSH, cagu_pkg::CAGU_STK_POP: next_r.last = 3'd2;
						cagu_pkg::CAGU_STK_RET: next_r.last = 3'd3;
						default: next_r.last = 3'd4;
					endcase
					next_r.status_load = status_push && stack_op_in == cagu_pkg::CAGU_STK_POP;
				end
			end
			CAGU_MOVE: begin
				next_r.req = 1'b1;
				next_r.step = r.step + 3'd1;
				next_r.status_load = r.status_load;
				if (r.table_fetch) begin
					next_r.addr = cagu_pkg::TABLE_BASE + {14'h0000, table_index_in, 1'b0} + {17'h0, r.step};
				end else unique case (r.op)
					cagu_pkg::CAGU_STK_PUSH, cagu_pkg::CAGU_STK_CALL, cagu_pkg::CAGU_STK_INT: begin
						next_r.we = 1'b1;
						next_r.addr = {cagu_pkg::MIRROR_BANK, r.base_sp - {13'h0000, r.step} - 16'h0001};
						next_r.wdata = frame_byte(r.op, r.step, r.frame[19:0], status_word_in, push_pair);
					end
					cagu_pkg::CAGU_STK_POP: begin
						next_r.addr = {cagu_pkg::MIRROR_BANK, r.base_sp + {13'h0000, r.step}};
						if (r.status_load && r.step == 3'd0)
							next_r.req = 1'b0;
					end
					default: next_r.addr = {cagu_pkg::MIRROR_BANK, r.base_sp + {13'h0000, r.step}};
				endcase
				if (r.step + 3'd1 == r.last)
					next_r.state = CAGU_WAIT;
			end
			CAGU_WAIT: begin
				next_r.state = CAGU_END;
				// status pop must still steer its byte in the next cycle
				next_r.status_load = r.status_load;
			end
			CAGU_END: begin
				next_r.state = CAGU_IDLE;
				next_r.done = 1'b1;
				if (r.table_fetch) begin
					next_r.table_fetch = 1'b0;
					// high table byte is on the bus in this cycle
					next_r.pc = {4'h0, mem_rdata_in, r.pop_data[7:0]};
					next_r.op = cagu_pkg::CAGU_STK_CALL;
					next_r.base_sp = r.sp;
					next_r.step = 3'd0;
					next_r.last = 3'd4;
					next_r.state = CAGU_MOVE;
					next_r.done = 1'b0;
				end else unique case (r.op)
					cagu_pkg::CAGU_STK_PUSH: next_r.sp = r.sp - cagu_pkg::SP_STEP_WORD;
					cagu_pkg::CAGU_STK_POP: begin
						next_r.sp = r.sp + cagu_pkg::SP_STEP_WORD;
						next_r.pair_load = !r.status_load;
						next_r.status_load = r.status_load;
					end
					cagu_pkg::CAGU_STK_CALL, cagu_pkg::CAGU_STK_INT:
						next_r.sp = r.sp - cagu_pkg::SP_STEP_FRAME;
					cagu_pkg::CAGU_STK_RET: begin
						next_r.sp = r.sp + cagu_pkg::SP_STEP_FRAME;
						// top frame byte is on the bus in this cycle
						next_r.pc = {mem_rdata_in[3:0], r.frame[15:0]};
					end
					default: begin
						next_r.sp = r.sp + cagu_pkg::SP_STEP_FRAME;
						next_r.pc = r.frame[19:0];
						next_r.status_load = 1'b1;
					end
				endcase
			end
		endcase
		// table entries land in pop_data while fetching
		if (r.table_fetch && r.rd_pending) begin
			if (r.rd_step == 3'd1)
				next_r.pop_data[7:0] = mem_rdata_in;
			else
				next_r.pop_data[15:8] = mem_rdata_in;
		end
		// returned frame byte 2 holds pc 19..16 in its low nibble
		if (r.rd_pending && r.rd_step == 3'd3 && !r.table_fetch && r.op != cagu_pkg::CAGU_STK_POP)
			next_r.frame[19:16] = mem_rdata_in[3:0];
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			r <= '0;
			r.sp <= cagu_pkg::SP_RESET;
			r.status <= cagu_pkg::STATUS_RESET;
			r.pc <= cagu_pkg::PC_RESET;
		end else begin
			r <= next_r;
		end
	end

	assign mem_req_out = r.req;
	assign mem_we_out = r.we;
	assign mem_addr_out = r.addr;
	assign mem_wdata_out = r.wdata;
	assign byte_reg_out = byte_val;
	assign pair_out = pair_val;
	assign program_counter_out = r.pc;
	assign stack_pointer_out = r.sp;
	assign status_word_out = r.status;
	assign pop_data_out = r.pop_data;
	assign status_load_out = r.status_load && r.done;
	assign pair_load_out = r.pair_load;
	assign busy_out = r.state != CAGU_IDLE;
	assign done_out = r.done;

	// ==========================================
	// checks
	property p_push_sp;
		@(posedge clk_in) disable iff (!reset_n_in)
		(r.state == CAGU_END && r.op == cagu_pkg::CAGU_STK_PUSH && !r.table_fetch) |=> (r.sp == $past(r.sp) - 16'h0002);
	endproperty
	a_push_sp: assert property (p_push_sp) else $error("push step wrong");
	property p_frame_sp;
		@(posedge clk_in) disable iff (!reset_n_in)
		(r.state == CAGU_END && !r.table_fetch && (r.op == cagu_pkg::CAGU_STK_CALL || r.op == cagu_pkg::CAGU_STK_INT))
			|=> (r.sp == $past(r.sp) - 16'h0004);
	endproperty
	a_frame_sp: assert property (p_frame_sp) else $error("frame step wrong");
	property p_ret_sp;
		@(posedge clk_in) disable iff (!reset_n_in)
		(r.state == CAGU_END && r.op == cagu_pkg::CAGU_STK_RET) |=> (r.sp == $past(r.sp) + 16'h0004);
	endproperty
	a_ret_sp: assert property (p_ret_sp) else $error("return step wrong");
	property p_stack_bank;
		@(posedge clk_in) disable iff (!reset_n_in)
		(mem_req_out && !r.table_fetch) |-> (mem_addr_out[19:16] == 4'hF);
	endproperty
	a_stack_bank: assert property (p_stack_bank) else $error("stack outside ram");
	property p_table_range;
		@(posedge clk_in) disable iff (!reset_n_in)
		(mem_req_out && r.table_fetch) |-> (mem_addr_out >= cagu_pkg::TABLE_BASE && mem_addr_out <= cagu_pkg::TABLE_LAST);
	endproperty
	a_table_range: assert property (p_table_range) else $error("table address out of range");
	property p_short_range;
		@(posedge clk_in) disable iff (!reset_n_in)
		(op_form_in == cagu_pkg::CAGU_OP_SHORT)
			|-> (operand_addr_out >= cagu_pkg::SHORT_BASE && operand_addr_out <= cagu_pkg::SHORT_LAST);
	endproperty
	a_short_range: assert property (p_short_range) else $error("short address out of range");
	property p_sfr_even;
		@(posedge clk_in) disable iff (!reset_n_in)
		(op_form_in == cagu_pkg::CAGU_OP_SFR && word_in) |-> (operand_addr_out[0] == 1'b0 && operand_addr_out[19:8] == 12'hFFF);
	endproperty
	a_sfr_even: assert property (p_sfr_even) else $error("sfr word address odd");
	property p_imm16;
		@(posedge clk_in) disable iff (!reset_n_in)
		(!busy_out && branch_in && branch_form_in == cagu_pkg::CAGU_BR_IMM && !imm_wide_in)
			|=> (program_counter_out[19:16] == 4'h0);
	endproperty
	a_imm16: assert property (p_imm16) else $error("upper pc bits not cleared");
	c_call: cover property (@(posedge clk_in) disable iff (!reset_n_in) r.state == CAGU_END && r.op == cagu_pkg::CAGU_STK_CALL);
	c_iret: cover property (@(posedge clk_in) disable iff (!reset_n_in) r.state == CAGU_END && r.op == cagu_pkg::CAGU_STK_IRET);
	c_table: cover property (@(posedge clk_in) disable iff (!reset_n_in) r.table_fetch && mem_req_out);
endmodule

// ==== cagu_pkg.sv ====
// Purpose: constants and types for the cpu address generation unit
// Assumes: 20-bit address space, 16-bit stack pointer inside the top 64 KB
// Notes: table, window and stack addresses, stack steps and reset values live here
package cagu_pkg;
	localparam int ADDR_W = 20;
	localparam logic [19:0] TABLE_BASE = 20'h00080;
	localparam logic [19:0] TABLE_LAST = 20'h000BF;
	localparam logic [3:0] MIRROR_BANK = 4'hF;
	localparam logic [19:0] SHORT_BASE = 20'hFFE20;
	localparam logic [19:0] SHORT_LAST = 20'hFFF1F;
	localparam logic [19:0] SFR_BASE = 20'hFFF00;
	localparam logic [7:0] SHORT_WRAP = 8'h20;
	localparam logic [15:0] SP_STEP_WORD = 16'h0002;
	localparam logic [15:0] SP_STEP_FRAME = 16'h0004;
	localparam logic [15:0] SP_RESET = 16'hFEE0;
	localparam logic [7:0] CALL_PAD = 8'h00;
	localparam logic [7:0] STATUS_PAD = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h06;
	localparam logic [19:0] PC_RESET = 20'h00000;
	localparam logic [1:0] THIRD_PAIR_SEL = 2'h3;

	// branch target forms
	typedef enum logic [1:0] {CAGU_BR_REL, CAGU_BR_IMM, CAGU_BR_TABLE, CAGU_BR_REG} cagu_br_t;
	// operand address forms
	typedef enum logic [2:0] {CAGU_OP_DIRECT, CAGU_OP_SHORT, CAGU_OP_SFR, CAGU_OP_INDIRECT,
		CAGU_OP_BASED, CAGU_OP_INDEXED} cagu_op_t;
	// base sources for based operands
	typedef enum logic [1:0] {CAGU_BASE_PAIR, CAGU_BASE_STACK, CAGU_BASE_IMM} cagu_base_t;
	// stack sequences
	typedef enum logic [2:0] {CAGU_STK_PUSH, CAGU_STK_POP, CAGU_STK_CALL, CAGU_STK_RET,
		CAGU_STK_INT, CAGU_STK_IRET} cagu_stk_t;
endpackage

// ==== cagu_operand.sv ====
// Purpose: combinational operand address former
// Assumes: register values supplied by the caller
// Notes: no state; pure address arithmetic
`timescale 1ns/1ps
module cagu_operand (
	// request
	input wire cagu_pkg::cagu_op_t form_in,
	input wire cagu_pkg::cagu_base_t base_sel_in,
	input wire logic seg_in,
	input wire logic word_in,
	input wire logic wide_offset_in,
	input wire logic [15:0] imm16_in,
	input wire logic [15:0] offset_in,
	input wire logic [7:0] field_in,
	// register values
	input wire logic [15:0] pair_in,
	input wire logic [15:0] third_pair_in,
	input wire logic [7:0] index_byte_in,
	input wire logic [15:0] stack_pointer_in,
	input wire logic [3:0] data_bank_register_in,
	// result
	output logic [19:0] addr_out
);
	logic [15:0] low;
	logic [15:0] base;
	logic [15:0] offs;
	logic [3:0] bank;
	logic [7:0] fld;
	always_comb begin
		fld = word_in ? {field_in[7:1], 1'b0} : field_in;
		bank = seg_in ? data_bank_register_in : cagu_pkg::MIRROR_BANK;
		unique case (base_sel_in)
			cagu_pkg::CAGU_BASE_STACK: base = stack_pointer_in;
			cagu_pkg::CAGU_BASE_IMM: base = imm16_in;
			default: base = pair_in;
		endcase
		offs = wide_offset_in ? offset_in : {8'h00, offset_in[7:0]};
		low = 16'h0000;
		addr_out = 20'h00000;
		unique case (form_in)
			cagu_pkg::CAGU_OP_DIRECT: addr_out = {bank, imm16_in};
			cagu_pkg::CAGU_OP_SHORT: begin
				// field below 20H wraps to the top of the window
				if (fld < cagu_pkg::SHORT_WRAP)
					addr_out = cagu_pkg::SFR_BASE + {12'h000, fld};
				else
					addr_out = {12'hFFE, fld};
			end
			cagu_pkg::CAGU_OP_SFR: addr_out = cagu_pkg::SFR_BASE | {12'h000, fld};
			cagu_pkg::CAGU_OP_INDIRECT: addr_out = {bank, pair_in};
			cagu_pkg::CAGU_OP_BASED: begin
				low = base + offs;
				addr_out = {bank, low};
			end
			cagu_pkg::CAGU_OP_INDEXED: begin
				low = third_pair_in + {8'h00, index_byte_in};
				addr_out = {bank, low};
			end
			default: addr_out = 20'h00000;
		endcase
	end
endmodule

// ==== cagu_mem_model.sv ====
// Purpose: byte memory standing behind the address unit's memory port
// Assumes: one byte per request, read data valid in the cycle after the read
// Notes: an idle data bus shows the inverse of its last value
`timescale 1ns/1ps
module cagu_mem_model (
	// clock
	input wire logic clk_in,
	// request
	input wire logic req_in,
	input wire logic we_in,
	input wire logic [19:0] addr_in,
	input wire logic [7:0] wdata_in,
	// answer
	output logic [7:0] rdata_out
);
	logic [7:0] mem [logic [19:0]];

	initial rdata_out = 8'h00;

	// ==========================================
	// storage and read port
	always @(posedge clk_in) begin
		if (req_in && we_in) begin
			mem[addr_in] = wdata_in;
		end
		if (req_in && !we_in) begin
			rdata_out <= mem[addr_in];
		end else begin
			// released bus does not keep the old byte
			rdata_out <= ~rdata_out;
		end
	end
endmodule

// ==== testbench.sv ====
// Purpose: self-checking bench for the address generation unit
// Assumes: memory model answers reads one cycle late
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module testbench;
	logic clk_in = 1'b0, reset_n_in = 1'b0, branch_in = 1'b0, imm_wide_in = 1'b0, disp_wide_in = 1'b0;
	logic seg_in = 1'b0, word_in = 1'b0, wide_offset_in = 1'b0, stack_req_in = 1'b0;
	cagu_pkg::cagu_br_t branch_form_in = cagu_pkg::CAGU_BR_REL;
	cagu_pkg::cagu_op_t op_form_in = cagu_pkg::CAGU_OP_DIRECT;
	cagu_pkg::cagu_base_t base_sel_in = cagu_pkg::CAGU_BASE_PAIR;
	cagu_pkg::cagu_stk_t stack_op_in = cagu_pkg::CAGU_STK_PUSH;
	logic [19:0] imm20_in = 20'h00000, next_pc_in = 20'h10000;
	logic [15:0] disp_in = 16'h0000, imm16_in = 16'h2000, offset_in = 16'h0310;
	logic [4:0] table_index_in = 5'h1F;
	logic [3:0] code_bank_in = 4'h7, data_bank_register_in = 4'h5;
	logic [2:0] byte_sel_in = 3'h3;
	logic [1:0] pair_sel_in = 2'h0;
	logic [63:0] bank_regs_in = 64'h1122334455667788;
	logic [7:0] status_word_in = 8'hA5, field_in = 8'h00;
	logic [7:0] mem_rdata_in, mem_wdata_out, byte_reg_out, status_word_out;
	logic [19:0] mem_addr_out, operand_addr_out, program_counter_out;
	logic [15:0] pair_out, stack_pointer_out, pop_data_out;
	logic mem_req_out, mem_we_out, status_load_out, pair_load_out, busy_out, done_out;
	int miscompares = 0;
	int tests_run = 0;

	always #2.5 clk_in = ~clk_in;

	cagu_top dut_u (.clk_in, .reset_n_in, .branch_in, .branch_form_in, .imm_wide_in, .disp_wide_in, .imm20_in,
		.disp_in, .table_index_in, .next_pc_in, .code_bank_in, .byte_sel_in, .pair_sel_in, .bank_regs_in,
		.data_bank_register_in, .status_word_in, .op_form_in, .base_sel_in, .seg_in, .word_in, .wide_offset_in,
		.imm16_in, .offset_in, .field_in, .stack_req_in, .stack_op_in, .mem_rdata_in, .mem_req_out, .mem_we_out,
		.mem_addr_out, .mem_wdata_out, .operand_addr_out, .byte_reg_out, .pair_out, .program_counter_out,
		.stack_pointer_out, .status_word_out, .pop_data_out, .status_load_out, .pair_load_out, .busy_out,
		.done_out);
	cagu_mem_model mem_u (.clk_in(clk_in), .req_in(mem_req_out), .we_in(mem_we_out), .addr_in(mem_addr_out),
		.wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));

	// ==========================================
	// shared tasks
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask

	task automatic chk_frame(input logic [15:0] sp, input logic [31:0] bytes4, input int n);
		for (int i = 0; i < n; i++) begin
			chk(mem_u.mem[{4'hF, sp - 16'(i + 1)}], bytes4[31 - 8 * i -: 8], "stack byte");
		end
	endtask

	// request held for one cycle, then wait for done within a bound
	task automatic run_op(input logic is_branch, input int exp_n);
		int n;
		@(negedge clk_in);
		branch_in = is_branch;
		stack_req_in = !is_branch;
		@(negedge clk_in);
		branch_in = 1'b0;
		stack_req_in = 1'b0;
		// the cycle in which the request is taken counts as the first
		n = 1;
		do begin
			@(posedge clk_in);
			#1;
			n++;
		end while (done_out !== 1'b1 && n < 40);
		if (done_out !== 1'b1) begin
			miscompares++;
			$display("ERROR %0t no completion", $time);
			tally_and_finish();
		end else if (exp_n > 0) begin
			chk(n, exp_n, "done latency");
		end
	endtask

	task automatic br(input cagu_pkg::cagu_br_t f, input logic w, input logic [19:0] exp, input string what);
		@(negedge clk_in);
		branch_form_in = f;
		imm_wide_in = w;
		disp_wide_in = w;
		branch_in = 1'b1;
		@(negedge clk_in);
		branch_in = 1'b0;
		@(negedge clk_in);
		chk(program_counter_out, exp, what);
	endtask

	task automatic opc(input cagu_pkg::cagu_op_t f, input cagu_pkg::cagu_base_t b, input logic s, input logic w,
		input logic [1:0] ps, input logic [7:0] fld, input logic [19:0] exp);
		@(negedge clk_in);
		op_form_in = f;
		base_sel_in = b;
		seg_in = s;
		word_in = w;
		wide_offset_in = w;
		pair_sel_in = ps;
		field_in = fld;
		#1;
		chk(operand_addr_out, exp, "operand address");
	endtask

	task automatic stk(input cagu_pkg::cagu_stk_t op, input logic s, input logic [1:0] ps, input int exp_n);
		@(negedge clk_in);
		stack_op_in = op;
		seg_in = s;
		pair_sel_in = ps;
		run_op(1'b0, exp_n);
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset();
		chk(program_counter_out, 20'h00000, "reset pc");
		chk(stack_pointer_out, 16'hFEE0, "reset sp");
		chk(status_word_out, 8'h06, "reset status");
		chk({busy_out, mem_req_out}, 2'h0, "reset idle");
	endtask

	task automatic t_operands();
		opc(cagu_pkg::CAGU_OP_DIRECT, cagu_pkg::CAGU_BASE_PAIR, 1'b0, 1'b0, 2'h0, 8'h00, 20'hF2000);
		opc(cagu_pkg::CAGU_OP_DIRECT, cagu_pkg::CAGU_BASE_PAIR, 1'b1, 1'b0, 2'h0, 8'h00, 20'h52000);
		opc(cagu_pkg::CAGU_OP_SHORT, cagu_pkg::CAGU_BASE_PAIR, 1'b0, 1'b0, 2'h0, 8'h20, 20'hFFE20);
		opc(cagu_pkg::CAGU_OP_SHORT, cagu_pkg::CAGU_BASE_PAIR, 1'b0, 1'b0, 2'h0, 8'h1F, 20'hFFF1F);
		opc(cagu_pkg::CAGU_OP_SHORT, cagu_pkg::CAGU_BASE_PAIR, 1'b0, 1'b1, 2'h0, 8'h31, 20'hFFE30);
		opc(cagu_pkg::CAGU_OP_SFR, cagu_pkg::CAGU_BASE_PAIR, 1'b0, 1'b0, 2'h0, 8'hFF, 20'hFFFFF);
		opc(cagu_pkg::CAGU_OP_SFR, cagu_pkg::CAGU_BASE_PAIR, 1'b0, 1'b1, 2'h0, 8'h41, 20'hFFF40);
		opc(cagu_pkg::CAGU_OP_INDIRECT, cagu_pkg::CAGU_BASE_PAIR, 1'b0, 1'b0, 2'h2, 8'h00, 20'hF3344);
		opc(cagu_pkg::CAGU_OP_INDIRECT, cagu_pkg::CAGU_BASE_PAIR, 1'b1, 1'b0, 2'h2, 8'h00, 20'h53344);
		opc(cagu_pkg::CAGU_OP_BASED, cagu_pkg::CAGU_BASE_PAIR, 1'b0, 1'b0, 2'h3, 8'h00, 20'hF1132);
		opc(cagu_pkg::CAGU_OP_BASED, cagu_pkg::CAGU_BASE_PAIR, 1'b0, 1'b1, 2'h3, 8'h00, 20'hF1432);
		opc(cagu_pkg::CAGU_OP_BASED, cagu_pkg::CAGU_BASE_STACK, 1'b0, 1'b0, 2'h0, 8'h00, 20'hFFEF0);
		opc(cagu_pkg::CAGU_OP_BASED, cagu_pkg::CAGU_BASE_IMM, 1'b0, 1'b1, 2'h0, 8'h00, 20'hF2310);
		opc(cagu_pkg::CAGU_OP_INDEXED, cagu_pkg::CAGU_BASE_PAIR, 1'b0, 1'b0, 2'h3, 8'h00, 20'hF1177);
		opc(cagu_pkg::CAGU_OP_INDEXED, cagu_pkg::CAGU_BASE_PAIR, 1'b1, 1'b0, 2'h3, 8'h00, 20'h51177);
		for (int i = 0; i < 8; i++) begin
			@(negedge clk_in);
			byte_sel_in = 3'(i);
			pair_sel_in = 2'(i);
			#1;
			chk(byte_reg_out, bank_regs_in[8 * i +: 8], "byte register");
			chk(pair_out, bank_regs_in[16 * (i % 4) +: 16], "register pair");
		end
		byte_sel_in = 3'h3;
	endtask

	task automatic t_branches();
		disp_in = 16'h0080;
		br(cagu_pkg::CAGU_BR_REL, 1'b0, 20'h0FF80, "short displacement");
		disp_in = 16'h8000;
		br(cagu_pkg::CAGU_BR_REL, 1'b1, 20'h08000, "long displacement");
		imm20_in = 20'hABCDE;
		br(cagu_pkg::CAGU_BR_IMM, 1'b1, 20'hABCDE, "wide immediate");
		br(cagu_pkg::CAGU_BR_IMM, 1'b0, 20'h0BCDE, "narrow immediate");
		pair_sel_in = 2'h3;
		br(cagu_pkg::CAGU_BR_REG, 1'b0, 20'h71122, "register target");
		// last table entry sits at 00BEH
		mem_u.mem[20'h000BE] = 8'h34;
		mem_u.mem[20'h000BF] = 8'h92;
		next_pc_in = 20'h3ABCD;
		branch_form_in = cagu_pkg::CAGU_BR_TABLE;
		run_op(1'b1, -1);
		@(negedge clk_in);
		chk(program_counter_out, 20'h09234, "table target");
		chk(stack_pointer_out, 16'hFEDC, "table frame sp");
		chk_frame(16'hFEE0, 32'h0003ABCD, 4);
	endtask

	task automatic t_stack();
		stk(cagu_pkg::CAGU_STK_PUSH, 1'b0, 2'h1, 5);
		chk_frame(16'hFEDC, 32'h55660000, 2);
		chk(stack_pointer_out, 16'hFEDA, "push sp");
		stk(cagu_pkg::CAGU_STK_POP, 1'b0, 2'h1, 5);
		chk({pair_load_out, pop_data_out}, 17'h15566, "pop pair");
		chk(stack_pointer_out, 16'hFEDC, "pop sp");
		stk(cagu_pkg::CAGU_STK_PUSH, 1'b1, 2'h0, 5);
		chk_frame(16'hFEDC, 32'hA5000000, 2);
		stk(cagu_pkg::CAGU_STK_POP, 1'b1, 2'h0, -1);
		chk({status_load_out, status_word_out}, 9'h1A5, "pop status");
		stk(cagu_pkg::CAGU_STK_RET, 1'b0, 2'h0, -1);
		chk(program_counter_out, 20'h3ABCD, "return pc");
		chk(stack_pointer_out, 16'hFEE0, "return sp");
		next_pc_in = 20'h41234;
		status_word_in = 8'h5A;
		stk(cagu_pkg::CAGU_STK_INT, 1'b0, 2'h0, 7);
		chk_frame(16'hFEE0, 32'h5A041234, 4);
		chk(stack_pointer_out, 16'hFEDC, "interrupt sp");
		stk(cagu_pkg::CAGU_STK_CALL, 1'b0, 2'h0, 7);
		chk_frame(16'hFEDC, 32'h00041234, 4);
		stk(cagu_pkg::CAGU_STK_RET, 1'b0, 2'h0, -1);
		stk(cagu_pkg::CAGU_STK_IRET, 1'b0, 2'h0, -1);
		chk({program_counter_out, status_word_out}, 28'h412345A, "interrupt return");
		chk(stack_pointer_out, 16'hFEE0, "interrupt return sp");
	endtask

	// ==========================================
	// main sequence
	initial begin
		repeat (2) @(negedge clk_in);
		t_reset();
		reset_n_in = 1'b1;
		t_operands();
		t_branches();
		t_stack();
		tally_and_finish();
	end
endmodule
